/* File: design/mcd_defines.svh */
// constants for the control-op and effective-address decoder
`ifndef MCD_DEFINES_SVH
`define MCD_DEFINES_SVH
`define MCD_OP_COPY_ACC_TO_INDEX 8'h97
`define MCD_OP_COPY_INDEX_TO_ACC 8'h9f
`define MCD_OP_SET_CARRY_FLAG    8'h99
`define MCD_OP_CLEAR_CARRY_FLAG  8'h98
`define MCD_OP_SET_IRQ_MASK      8'h9b
`define MCD_OP_CLEAR_IRQ_MASK    8'h9a
`define MCD_OP_SOFTWARE_TRAP     8'h83
`define MCD_OP_RETURN_FROM_SUB   8'h81
`define MCD_OP_RETURN_FROM_IRQ   8'h80
`define MCD_OP_STACK_PTR_RESET   8'h9c
`define MCD_OP_NO_OPERATION      8'h9d
`define MCD_OP_STOP              8'h8e
`define MCD_OP_WAIT              8'h8f
`define MCD_OP_UNSIGNED_PRODUCT  8'h42
`define MCD_OP_SHIFT_RIGHT_ACC   8'h44
`define MCD_OP_SHIFT_RIGHT_IDX   8'h54
`define MCD_CYC_CTRL             4'h2
`define MCD_CYC_SOFTWARE_TRAP    4'ha
`define MCD_CYC_RETURN_FROM_IRQ  4'h9
`define MCD_CYC_RETURN_FROM_SUB  4'h6
`define MCD_CYC_UNSIGNED_PRODUCT 4'hb
`define MCD_CYC_SHIFT_INHERENT   4'h3
`define MCD_SP_RESET             8'hff
`define MCD_PC_RESET             16'h0000
`define MCD_CC_RESET             5'h08
`endif

/* File: design/mcd_pkg.sv */
// types shared by the decoder and the address unit
package mcd_pkg;
  typedef enum logic [3:0] {
    MCD_AM_INH, MCD_AM_IMM, MCD_AM_DIR, MCD_AM_EXT, MCD_AM_REL,
    MCD_AM_IX0, MCD_AM_IX1, MCD_AM_IX2, MCD_AM_BSC, MCD_AM_BTB
  } mcd_mode_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } mcd_cc_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } mcd_instr_t;

  // addressing mode from the opcode row
  function automatic mcd_mode_t mcd_mode_of(input logic [7:0] op);
    case (op[7:4])
      4'h0: mcd_mode_of = MCD_AM_BTB;
      4'h1: mcd_mode_of = MCD_AM_BSC;
      4'h2: mcd_mode_of = MCD_AM_REL;
      4'h3: mcd_mode_of = MCD_AM_DIR;
      4'h6: mcd_mode_of = MCD_AM_IX1;
      4'h7: mcd_mode_of = MCD_AM_IX0;
      4'ha: mcd_mode_of = MCD_AM_IMM;
      4'hb: mcd_mode_of = MCD_AM_DIR;
      4'hc: mcd_mode_of = MCD_AM_EXT;
      4'hd: mcd_mode_of = MCD_AM_IX2;
      4'he: mcd_mode_of = MCD_AM_IX1;
      4'hf: mcd_mode_of = MCD_AM_IX0;
      default: mcd_mode_of = MCD_AM_INH;
    endcase
  endfunction
endpackage

/* File: design/mcd_ea_unit.sv */
// effective address and next program counter for one instruction
`timescale 1ns/1ps
module mcd_ea_unit
  import mcd_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_load,
  input  wire mcd_mode_t  i_mode,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0] i_idx,
  input  wire logic [7:0] i_byte1,
  input  wire logic [7:0] i_byte2,
  output logic [15:0]     o_ea,
  output logic [15:0]     o_pc_next,
  output logic [15:0]     o_br_target
);
  logic [15:0] ea_next;
  logic [15:0] len_next;

  // address and length per mode; inherent fetches nothing
  always_comb begin
    ea_next  = 16'h0000;
    len_next = 16'h0001;
    case (i_mode)
      MCD_AM_INH: len_next = 16'h0001;
      MCD_AM_IMM: begin
        ea_next  = 16'(i_pc + 16'h0001);
        len_next = 16'h0002;
      end
      MCD_AM_DIR, MCD_AM_BSC: begin
        ea_next  = {8'h00, i_byte1};
        len_next = 16'h0002;
      end
      MCD_AM_EXT: begin
        ea_next  = {i_byte1, i_byte2};
        len_next = 16'h0003;
      end
      MCD_AM_REL: len_next = 16'h0002;
      MCD_AM_IX0: ea_next = {8'h00, i_idx};
      MCD_AM_IX1: begin
        ea_next  = {8'h00, i_idx} + {8'h00, i_byte1};
        len_next = 16'h0002;
      end
      MCD_AM_IX2: begin
        ea_next  = 16'({i_byte1, i_byte2} + {8'h00, i_idx});
        len_next = 16'h0003;
      end
      MCD_AM_BTB: begin
        ea_next  = {8'h00, i_byte1};
        len_next = 16'h0003;
      end
      default: ea_next = 16'h0000;
    endcase
  end

  // results are held until the next instruction is taken
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ea        <= 16'h0000;
      o_pc_next   <= 16'h0000;
      o_br_target <= 16'h0000;
    end else if (i_load) begin
      o_ea        <= ea_next;
      o_pc_next   <= 16'(i_pc + len_next);
      // offset counts from the end of the three-byte instruction
      o_br_target <= 16'(i_pc + 16'h0003 + {{8{i_byte2[7]}}, i_byte2});
    end
  end
endmodule // mcd_ea_unit

/* File: design/mcd_ctrl_decode.sv */
// control-op execution, flag update and address sequencing for the core
`timescale 1ns/1ps
`include "mcd_defines.svh"
module mcd_ctrl_decode
  import mcd_pkg::*;
#(
  parameter logic [3:0] P_BTB_CYCLES = 4'h5,
  parameter logic [3:0] P_MEM_CYCLES = 4'h3
)(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire mcd_instr_t i_instr,
  input  wire logic [7:0] i_bus_rdata,
  input  wire mcd_cc_t    i_stack_cc,
  input  wire logic [15:0] i_stack_pc,
  input  wire logic [15:0] i_trap_vec,
  input  wire logic       i_wake,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_undef,
  output logic [7:0]      o_acc,
  output logic [7:0]      o_idx,
  output logic [7:0]      o_sp,
  output logic [15:0]     o_pc,
  output mcd_cc_t         o_cc,
  output logic [15:0]     o_ea,
  output logic            o_ea_valid,
  output logic            o_bus_rd,
  output logic [15:0]     o_bus_addr,
  output logic            o_wait_mode,
  output logic            o_stop_mode
);
  logic        busy_reg;
  logic [3:0]  cnt_reg;
  logic [3:0]  total_reg;
  mcd_instr_t  ir_reg;
  mcd_mode_t   mode_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  idx_reg;
  logic [7:0]  sp_reg;
  logic [15:0] pc_reg;
  mcd_cc_t     cc_reg;
  logic        done_reg;
  logic        undef_reg;
  logic        ea_valid_reg;
  logic        bus_rd_reg;
  logic        wait_reg;
  logic        stop_reg;
  logic [15:0] ea_w;
  logic [15:0] pc_next_w;
  logic [15:0] br_target_w;
  logic        start_ok;
  logic        last;
  logic [7:0]  op;
  logic [15:0] product;
  logic [7:0]  shift_src;
  logic [7:0]  shift_res;
  logic        btb_taken;

  // cycles an opcode occupies; address-only rows use a fixed count
  function automatic logic [3:0] cycles_of(input logic [7:0] opc);
    case (opc)
      `MCD_OP_SOFTWARE_TRAP:    cycles_of = `MCD_CYC_SOFTWARE_TRAP;
      `MCD_OP_RETURN_FROM_IRQ:  cycles_of = `MCD_CYC_RETURN_FROM_IRQ;
      `MCD_OP_RETURN_FROM_SUB:  cycles_of = `MCD_CYC_RETURN_FROM_SUB;
      `MCD_OP_UNSIGNED_PRODUCT: cycles_of = `MCD_CYC_UNSIGNED_PRODUCT;
      `MCD_OP_SHIFT_RIGHT_ACC,
      `MCD_OP_SHIFT_RIGHT_IDX:  cycles_of = `MCD_CYC_SHIFT_INHERENT;
      default: begin
        if (opc[7:4] == 4'h0)
          cycles_of = P_BTB_CYCLES;
        else if (opc[7:4] == 4'h8 || opc[7:4] == 4'h9)
          cycles_of = `MCD_CYC_CTRL;
        else
          cycles_of = P_MEM_CYCLES;
      end
    endcase
  endfunction

  // holes in the map; other rows are taken as address-only ops
  function automatic logic is_undef(input logic [7:0] opc);
    case (opc)
      `MCD_OP_COPY_ACC_TO_INDEX, `MCD_OP_COPY_INDEX_TO_ACC,
      `MCD_OP_SET_CARRY_FLAG, `MCD_OP_CLEAR_CARRY_FLAG,
      `MCD_OP_SET_IRQ_MASK, `MCD_OP_CLEAR_IRQ_MASK,
      `MCD_OP_SOFTWARE_TRAP, `MCD_OP_RETURN_FROM_SUB,
      `MCD_OP_RETURN_FROM_IRQ, `MCD_OP_STACK_PTR_RESET,
      `MCD_OP_NO_OPERATION, `MCD_OP_STOP, `MCD_OP_WAIT,
      `MCD_OP_UNSIGNED_PRODUCT: is_undef = 1'b0;
      default: begin
        if (opc[7:4] == 4'h8 || opc[7:4] == 4'h9)
          is_undef = 1'b1;
        else if (opc[7:4] >= 4'h3 && opc[7:4] <= 4'h7)
          is_undef = (opc[3:0] == 4'h1) || (opc[3:0] == 4'h2) ||
                     (opc[3:0] == 4'h5) || (opc[3:0] == 4'hb) ||
                     (opc[3:0] == 4'he);
        else
          is_undef = 1'b0;
      end
    endcase
  endfunction

  // a new instruction is only taken while idle
  assign start_ok = i_start & ~busy_reg;
  assign last     = busy_reg & (cnt_reg == 4'(total_reg - 4'h1));
  assign op       = ir_reg.opcode;

  // datapath terms used at completion
  assign product   = {8'h00, idx_reg} * {8'h00, acc_reg};
  assign shift_src = (op == `MCD_OP_SHIFT_RIGHT_IDX) ? idx_reg : acc_reg;
  assign shift_res = {1'b0, shift_src[7:1]};
  // even opcodes branch on a set bit, odd ones on a clear bit
  assign btb_taken = (rdata_reg[op[3:1]] == ~op[0]);

  mcd_ea_unit u_ea (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_load      (start_ok),
    .i_mode      (mcd_mode_of(i_instr.opcode)),
    .i_pc        (pc_reg),
    .i_idx       (idx_reg),
    .i_byte1     (i_instr.byte1),
    .i_byte2     (i_instr.byte2),
    .o_ea        (ea_w),
    .o_pc_next   (pc_next_w),
    .o_br_target (br_target_w)
  );

  // sequencing: cycle counter from the start edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg  <= 1'b0;
      cnt_reg   <= 4'h0;
      total_reg <= 4'h0;
      ir_reg    <= '0;
      mode_reg  <= MCD_AM_INH;
    end else if (start_ok) begin
      busy_reg  <= 1'b1;
      cnt_reg   <= 4'h1;
      total_reg <= cycles_of(i_instr.opcode);
      ir_reg    <= i_instr;
      mode_reg  <= mcd_mode_of(i_instr.opcode);
    end else if (last) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 4'h0;
    end else if (busy_reg) begin
      cnt_reg <= 4'(cnt_reg + 4'h1);
    end
  end

  // completion and undefined-opcode pulses
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_reg  <= 1'b0;
      undef_reg <= 1'b0;
    end else begin
      done_reg  <= last;
      undef_reg <= last & is_undef(op);
    end
  end

  // address is shown once it is formed; only the bit-test reads memory
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ea_valid_reg <= 1'b0;
      bus_rd_reg   <= 1'b0;
      o_bus_addr   <= 16'h0000;
      rdata_reg    <= 8'h00;
    end else begin
      ea_valid_reg <= busy_reg & (cnt_reg == 4'h1) & (mode_reg != MCD_AM_INH);
      bus_rd_reg   <= busy_reg & (cnt_reg == 4'h1) & (mode_reg == MCD_AM_BTB);
      if (busy_reg && cnt_reg == 4'h1)
        o_bus_addr <= ea_w;
      // memory answers one cycle after the read strobe
      if (busy_reg && cnt_reg == 4'h3 && mode_reg == MCD_AM_BTB)
        rdata_reg <= i_bus_rdata;
    end
  end

  // accumulator and index updates
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= 8'h00;
      idx_reg <= 8'h00;
    end else if (last) begin
      case (op)
        `MCD_OP_COPY_ACC_TO_INDEX: idx_reg <= acc_reg;
        `MCD_OP_COPY_INDEX_TO_ACC: acc_reg <= idx_reg;
        `MCD_OP_UNSIGNED_PRODUCT: begin
          idx_reg <= product[15:8];
          acc_reg <= product[7:0];
        end
        `MCD_OP_SHIFT_RIGHT_ACC: acc_reg <= shift_res;
        `MCD_OP_SHIFT_RIGHT_IDX: idx_reg <= shift_res;
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  // condition codes; untouched flags keep their value
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cc_reg <= `MCD_CC_RESET;
    end else if (last) begin
      case (op)
        `MCD_OP_SET_CARRY_FLAG:   cc_reg.c <= 1'b1;
        `MCD_OP_CLEAR_CARRY_FLAG: cc_reg.c <= 1'b0;
        `MCD_OP_SET_IRQ_MASK:     cc_reg.i <= 1'b1;
        `MCD_OP_CLEAR_IRQ_MASK:   cc_reg.i <= 1'b0;
        `MCD_OP_SOFTWARE_TRAP:    cc_reg.i <= 1'b1;
        `MCD_OP_RETURN_FROM_IRQ:  cc_reg   <= i_stack_cc;
        `MCD_OP_STOP, `MCD_OP_WAIT: cc_reg.i <= 1'b0;
        `MCD_OP_UNSIGNED_PRODUCT: begin
          cc_reg.h <= 1'b0;
          cc_reg.c <= 1'b0;
        end
        `MCD_OP_SHIFT_RIGHT_ACC, `MCD_OP_SHIFT_RIGHT_IDX: begin
          cc_reg.n <= 1'b0;
          cc_reg.z <= (shift_res == 8'h00);
          cc_reg.c <= shift_src[0];
        end
        default: cc_reg <= cc_reg;
      endcase
    end
  end

  // stack pointer
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      sp_reg <= `MCD_SP_RESET;
    else if (last && op == `MCD_OP_STACK_PTR_RESET)
      sp_reg <= `MCD_SP_RESET;
  end

  // program counter; returns and the trap take it from outside
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_reg <= `MCD_PC_RESET;
    end else if (last) begin
      case (op)
        `MCD_OP_RETURN_FROM_IRQ,
        `MCD_OP_RETURN_FROM_SUB: pc_reg <= i_stack_pc;
        `MCD_OP_SOFTWARE_TRAP:   pc_reg <= i_trap_vec;
        default: begin
          if (mode_reg == MCD_AM_BTB && btb_taken)
            pc_reg <= br_target_w;
          else
            pc_reg <= pc_next_w;
        end
      endcase
    end
  end

  // low-power modes hold until woken; wake wins only after entry
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else if (last && op == `MCD_OP_WAIT) begin
      wait_reg <= 1'b1;
    end else if (last && op == `MCD_OP_STOP) begin
      stop_reg <= 1'b1;
    end else if (i_wake) begin
      wait_reg <= 1'b0;
      stop_reg <= 1'b0;
    end
  end

  // all outputs come straight from flip-flops
  assign o_busy      = busy_reg;
  assign o_done      = done_reg;
  assign o_undef     = undef_reg;
  assign o_acc       = acc_reg;
  assign o_idx       = idx_reg;
  assign o_sp        = sp_reg;
  assign o_pc        = pc_reg;
  assign o_cc        = cc_reg;
  assign o_ea        = ea_w;
  assign o_ea_valid  = ea_valid_reg;
  assign o_bus_rd    = bus_rd_reg;
  assign o_wait_mode = wait_reg;
  assign o_stop_mode = stop_reg;
endmodule // mcd_ctrl_decode

/* File: verif/mcd_ctrl_monitor.sv */
// checker on the decoder's ports: cycle counts, flag updates and addresses
`timescale 1ns/1ps
module mcd_ctrl_monitor
  import mcd_pkg::*;
#(
  parameter logic [3:0] P_BTB_CYCLES = 4'h5,
  parameter logic [3:0] P_MEM_CYCLES = 4'h3
)(
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_start,
  input wire mcd_instr_t  i_instr,
  input wire logic [7:0]  i_bus_rdata,
  input wire mcd_cc_t     i_stack_cc,
  input wire logic [15:0] i_stack_pc,
  input wire logic [15:0] i_trap_vec,
  input wire logic        i_wake,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_undef,
  input wire logic [7:0]  o_acc,
  input wire logic [7:0]  o_idx,
  input wire logic [7:0]  o_sp,
  input wire logic [15:0] o_pc,
  input wire mcd_cc_t     o_cc,
  input wire logic [15:0] o_ea,
  input wire logic        o_ea_valid,
  input wire logic        o_bus_rd,
  input wire logic [15:0] o_bus_addr,
  input wire logic        o_wait_mode,
  input wire logic        o_stop_mode
);
  logic [7:0]  op_reg, b1_reg, b2_reg, x_reg, acc_reg, idx_reg;
  logic [15:0] pc_reg;
  mcd_cc_t     cc_reg;
  logic        take;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  assign take = i_start && !o_busy;

  // fields held from the taking edge; state one cycle old gives the value before completion
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {op_reg, b1_reg, b2_reg, x_reg, pc_reg} <= 48'h0;
      {acc_reg, idx_reg, cc_reg} <= 21'h0;
    end else begin
      if (take) {op_reg, b1_reg, b2_reg, x_reg, pc_reg} <= {i_instr, o_idx, o_pc};
      {acc_reg, idx_reg, cc_reg} <= {o_acc, o_idx, o_cc};
    end
  end

  // expected address by opcode row; direct-page rows fall to the default
  function automatic logic [15:0] ea_of(input logic [7:0] op, b1, b2, x, input logic [15:0] pc);
    case (op[7:4])
      4'ha: ea_of = pc + 16'h0001;
      4'hc: ea_of = {b1, b2};
      4'hd: ea_of = {b1, b2} + {8'h00, x};
      4'h6, 4'he: ea_of = {8'h00, b1} + {8'h00, x};
      4'h7, 4'hf: ea_of = {8'h00, x};
      default: ea_of = {8'h00, b1};
    endcase
  endfunction

  property p_ctrl_len;
    take && i_instr.opcode inside {8'h97, 8'h9f, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d,
      8'h8e, 8'h8f} |=> o_busy ##1 (o_done && !o_busy);
  endproperty
  a_ctrl_len: assert property (p_ctrl_len)
    else $error("control op not done in two cycles");
  property p_trap_len;
    take && i_instr.opcode == 8'h83 |=> o_busy [*8] ##1 o_busy ##1 o_done;
  endproperty
  a_trap_len: assert property (p_trap_len) else $error("trap length wrong");
  property p_rti_len;
    take && i_instr.opcode == 8'h80 |=> o_busy [*8] ##1 o_done;
  endproperty
  a_rti_len: assert property (p_rti_len) else $error("irq return length wrong");
  property p_flag_ops;
    o_done && op_reg inside {8'h98, 8'h99, 8'h9a, 8'h9b} |-> o_cc == (op_reg[1] ?
      {cc_reg.h, op_reg[0], cc_reg[2:0]} : {cc_reg[4:1], op_reg[0]});
  endproperty
  a_flag_ops: assert property (p_flag_ops) else $error("flag op result wrong");
  property p_product;
    o_done && op_reg == 8'h42 |-> {o_idx, o_acc} == {8'h00, idx_reg} * {8'h00, acc_reg}
      && o_cc == {1'b0, cc_reg[3:1], 1'b0};
  endproperty
  a_product: assert property (p_product) else $error("product wrong");
  property p_shift;
    o_done && op_reg inside {8'h44, 8'h54} |-> (op_reg[4] ? o_idx == {1'b0, idx_reg[7:1]} :
      o_acc == {1'b0, acc_reg[7:1]}) && o_cc == {cc_reg[4:3], 1'b0,
      (op_reg[4] ? o_idx : o_acc) == 8'h00, (op_reg[4] ? idx_reg[0] : acc_reg[0])};
  endproperty
  a_shift: assert property (p_shift) else $error("right shift wrong");
  property p_ea;
    o_ea_valid && op_reg[7:4] != 4'h2 |-> o_ea == ea_of(op_reg, b1_reg, b2_reg, x_reg, pc_reg);
  endproperty
  a_ea: assert property (p_ea) else $error("address wrong");
  property p_bus;
    o_bus_rd |-> o_ea_valid && o_bus_addr == {8'h00, b1_reg} && op_reg[7:4] == 4'h0;
  endproperty
  a_bus: assert property (p_bus) else $error("bit-test read address wrong");
  property p_undef;
    o_undef |-> o_done;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined pulse without done");
  property p_low_power;
    o_done && op_reg inside {8'h8e, 8'h8f} |-> !o_cc.i && (op_reg[0] ? o_wait_mode : o_stop_mode);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power entry wrong");

  c_trap: cover property (take && i_instr.opcode == 8'h83);
  c_bus_read: cover property (o_bus_rd);
  c_back_to_back: cover property (o_done && take);
endmodule // mcd_ctrl_monitor

/* File: verif/mcd_mem_model.sv */
// data memory answering the bit-test read strobe
`timescale 1ns/1ps
module mcd_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:255];  // loaded by the bench

  // data is valid only the cycle after the strobe; elsewhere it toggles so a late sample fails
  initial o_rdata = 8'h00;
  always @(posedge i_clk_sys) begin
    if (i_rd) o_rdata <= mem[i_addr[7:0]];
    else o_rdata <= ~o_rdata;
  end
endmodule // mcd_mem_model

/* File: verif/testbench.sv */
// self-checking bench for the control-op and address decoder
`timescale 1ns/1ps
module testbench
  import mcd_pkg::*;
;
  typedef struct packed {
    logic [15:0] pc;
    mcd_cc_t     cc;
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [7:0]  sp;
    logic        undef;
    logic        wt;
    logic        st;
  } mcd_note_t;
  logic        i_clk_sys, i_rst_n, i_start, i_wake, o_busy, o_done, o_undef, o_ea_valid;
  logic        o_bus_rd, o_wait_mode, o_stop_mode;
  mcd_instr_t  i_instr;
  mcd_cc_t     i_stack_cc, o_cc;
  logic [7:0]  i_bus_rdata, o_acc, o_idx, o_sp, op;
  logic [15:0] i_stack_pc, i_trap_vec, o_pc, o_ea, o_bus_addr;
  mcd_note_t   notes[$];
  mcd_note_t   m, seen;
  logic [7:0]  ctl [14] = '{8'h97, 8'h9f, 8'h99, 8'h98, 8'h9b, 8'h9a, 8'h83, 8'h81, 8'h80,
                           8'h9c, 8'h9d, 8'h42, 8'h44, 8'h54};
  int          n_mismatch = 0;
  int          checks = 0;

  assign seen = {o_pc, o_cc, o_acc, o_idx, o_sp, o_undef, o_wait_mode, o_stop_mode};

  mcd_ctrl_decode #(.P_BTB_CYCLES(4'h5), .P_MEM_CYCLES(4'h3)) dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start), .i_instr(i_instr),
    .i_bus_rdata(i_bus_rdata), .i_stack_cc(i_stack_cc), .i_stack_pc(i_stack_pc),
    .i_trap_vec(i_trap_vec), .i_wake(i_wake), .o_busy(o_busy), .o_done(o_done),
    .o_undef(o_undef), .o_acc(o_acc), .o_idx(o_idx), .o_sp(o_sp), .o_pc(o_pc), .o_cc(o_cc),
    .o_ea(o_ea), .o_ea_valid(o_ea_valid), .o_bus_rd(o_bus_rd), .o_bus_addr(o_bus_addr),
    .o_wait_mode(o_wait_mode), .o_stop_mode(o_stop_mode));
  mcd_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_rd(o_bus_rd), .i_addr(o_bus_addr),
    .o_rdata(i_bus_rdata));

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input string nm, input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // expected state is noted before the take; poke offers a refused op while busy
  task automatic issue(input logic [7:0] op, b1, b2, input bit poke);
    mcd_note_t n;
    int        k;
    i_stack_pc = 16'($urandom);
    i_stack_cc = 5'($urandom);
    i_trap_vec = 16'($urandom);
    n = m;
    case (op[7:4])
      4'h1, 4'h3, 4'h6, 4'ha, 4'hb, 4'he: n.pc = m.pc + 16'h0002;
      4'h0, 4'hc, 4'hd: n.pc = m.pc + 16'h0003;
      default: n.pc = m.pc + 16'h0001;
    endcase
    if (op[7:4] == 4'h0 && u_mem.mem[b1][op[3:1]] == !op[0]) n.pc += {{8{b2[7]}}, b2};
    n.undef = op[7:4] inside {[4'h3:4'h7]} && op[3:0] inside {4'h1, 4'h2, 4'h5, 4'hb, 4'he}
      && op != 8'h42;
    case (op)
      8'h97: n.idx = m.acc;
      8'h9f: n.acc = m.idx;
      8'h98, 8'h99: n.cc.c = op[0];
      8'h9a, 8'h9b: n.cc.i = op[0];
      8'h83: {n.cc.i, n.pc} = {1'b1, i_trap_vec};
      8'h81: n.pc = i_stack_pc;
      8'h80: {n.cc, n.pc} = {i_stack_cc, i_stack_pc};
      8'h9c: n.sp = 8'hff;
      8'h9d: n.sp = m.sp;
      8'h8e, 8'h8f: {n.cc.i, n.wt, n.st} = {1'b0, op[0], !op[0]};
      8'h42: {n.idx, n.acc, n.cc.h, n.cc.c} = {16'(m.idx) * 16'(m.acc), 2'b00};
      8'h44, 8'h54: begin
        {n.cc.n, n.cc.c} = {1'b0, op[4] ? m.idx[0] : m.acc[0]};
        if (op[4]) n.idx = m.idx >> 1;
        else n.acc = m.acc >> 1;
        n.cc.z = (op[4] ? n.idx : n.acc) == 8'h00;
      end
      default: if (op[7:5] == 3'b100) n.undef = 1'b1;
    endcase
    notes.push_back(n);
    m = n;
    i_instr = {op, b1, b2};
    i_start = 1'b1;
    @(posedge i_clk_sys);
    #1 i_start = 1'b0;
    if (poke) begin
      @(posedge i_clk_sys);
      #1 i_instr.opcode = 8'h9a;
      i_start = 1'b1;
      @(posedge i_clk_sys);
      #1 i_start = 1'b0;
    end
    k = 0;
    while (o_done !== 1'b1 && k < 16) begin
      @(posedge i_clk_sys);
      #1 k++;
    end
    // a hang on one instruction counts against the run
    if (k >= 16) check("done timeout", 48'(o_done), 48'h1);
  endtask

  task automatic wake();
    i_wake = 1'b1;
    @(posedge i_clk_sys);
    #1 i_wake = 1'b0;
    {m.wt, m.st} = 2'b00;
    check("low power levels", 48'({o_wait_mode, o_stop_mode}), 48'h0);
  endtask

  // scoreboard: each completion takes the oldest note
  initial forever begin
    @(posedge i_clk_sys);
    #1;
    if (o_done === 1'b1) begin
      if (notes.size() == 0) check("unexpected done", 48'h1, 48'h0);
      else check("state", seen, notes.pop_front());
    end
  end

  initial begin
    #(8 * 20000);
    n_mismatch++;
    test_done();
  end

  initial begin
    void'($urandom(74593));
    {i_rst_n, i_start, i_wake} = 3'b000;
    {i_instr, i_stack_cc, i_stack_pc, i_trap_vec} = '0;
    for (int a = 0; a < 256; a++) u_mem.mem[a] = 8'($urandom);
    repeat (3) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    m = {16'h0000, 5'h08, 8'h00, 8'h00, 8'hff, 3'b000};
    check("reset", seen, m);
    // every control op but STOP and WAIT back to back, trap with a refused request inside it
    for (int k = 0; k < 14; k++) issue(ctl[k], 8'($urandom), 8'($urandom), ctl[k] == 8'h83);
    issue(8'h8e, 8'h00, 8'h00, 1'b0);
    wake();
    issue(8'h8f, 8'h00, 8'h00, 1'b0);
    wake();
    // relative rows and low-power ops are left out of the random mix
    for (int k = 0; k < 300; k++) begin
      op = 8'($urandom);
      if (op[7:4] == 4'h2 || op[7:1] == 7'h47) op = 8'h9d;
      issue(op, 8'($urandom), 8'($urandom), 1'b0);
    end
    repeat (4) @(posedge i_clk_sys);
    check("pending notes", 48'(notes.size()), 48'h0);
    test_done();
  end
endmodule // testbench

bind mcd_ctrl_decode mcd_ctrl_monitor #(.P_BTB_CYCLES(P_BTB_CYCLES),
  .P_MEM_CYCLES(P_MEM_CYCLES)) u_mon (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start), .i_instr(i_instr),
  .i_bus_rdata(i_bus_rdata), .i_stack_cc(i_stack_cc), .i_stack_pc(i_stack_pc),
  .i_trap_vec(i_trap_vec), .i_wake(i_wake), .o_busy(o_busy), .o_done(o_done),
  .o_undef(o_undef), .o_acc(o_acc), .o_idx(o_idx), .o_sp(o_sp), .o_pc(o_pc), .o_cc(o_cc),
  .o_ea(o_ea), .o_ea_valid(o_ea_valid), .o_bus_rd(o_bus_rd), .o_bus_addr(o_bus_addr),
  .o_wait_mode(o_wait_mode), .o_stop_mode(o_stop_mode));
